// ### inc/alarm_code_pkg.sv
// constants for the far-end alarm code word controller
// assumes a 16-bit host register port and one overhead bit slot per direction
package alarm_code_pkg;
  // register map (word offsets on the plain port)
  localparam logic [7:0]  ALARM_CODE_CONTROL_OFS = 8'h90;
  localparam logic [7:0]  ALARM_CODE_STATUS_OFS  = 8'h92;
  // control field positions
  localparam int          CTL_WORD_A_LSB   = 0;
  localparam int          CTL_SEL_LSB      = 6;
  localparam int          CTL_WORD_B_LSB   = 8;
  localparam int          CTL_IDLE_IE_BIT  = 14;
  localparam int          CTL_RX_RESET_BIT = 15;
  localparam logic [15:0] CTL_RESET_VALUE  = 16'h0000;
  // status field positions
  localparam int          STS_DETECTED_BIT = 0;
  localparam int          STS_IDLE_BIT     = 1;
  localparam int          STS_PAYLOAD_LSB  = 8;
  localparam int          STS_EMPTY_BIT    = 14;
  localparam int          STS_OVERFLOW_BIT = 15;
  // code word shape
  localparam int          WORD_BITS        = 16;
  localparam logic [7:0]  WORD_FLAG        = 8'hff;
  localparam int          TX_REPEATS       = 10;
  localparam int          RX_VALIDATE_CNT  = 3;
  localparam int          RX_LOSS_CNT      = 2;
  localparam int          RX_IDLE_ONES     = 16;
  localparam int          RX_FIFO_DEPTH    = 4;
  // transmit select encodings
  localparam logic [1:0]  SEL_IDLE         = 2'h0;
  localparam logic [1:0]  SEL_A_ONCE       = 2'h1;
  localparam logic [1:0]  SEL_A_THEN_B     = 2'h2;
  localparam logic [1:0]  SEL_A_CONT       = 2'h3;
  typedef enum logic [1:0] {TX_IDLE, TX_SEND_A, TX_SEND_B, TX_DONE} tx_state_t;
endpackage : alarm_code_pkg

// ### design/far_end_alarm_code_ctrl.sv
// far-end alarm code word controller: transmit generator, receive detector, 4-entry queue
// assumes framer gives one-cycle bit-slot strobes on mclk; mode pins from framer config
//
// Function
// - in T3 mode the block only works when C-bit parity framing is on.
// - in E3 mode transmit drives the spare bit only when source select picks it.
// - in E3 mode the receive detector always runs and updates status.
// - code word is eight ones, zero, six payload bits, zero; lsb first.
// - each code word goes out at least ten times; otherwise send all ones.
// - receive search slides one bit at a time with no assumed alignment.
// - a word validates after the same payload in three consecutive opportunities.
// - a validated word is lost after two bad opportunities in a row.
// - validation sets the detected flag and pushes the payload into the queue.
// - the receive queue holds four entries.
// - on a full queue a new word is dropped and overflow is set.
// - control bits 0 to 5 hold word A payload, bit 0 sent first.
// - control bits 8 to 13 hold word B payload, bit 8 sent first.
// - transmit select acts on change; host returns to idle between actions.
// - select 00 sends ones; 01 sends word A ten times then ones.
// - select 10 sends word A ten times, word B ten times, then ones.
// - select 11 repeats word A while held, never fewer than ten.
// - control bit 14 masks or unmasks the receive idle interrupt.
// - a rising control bit 15 resets receive logic and flushes the queue.
// - detected flag latches per new word and clears on status read.
// - idle flag latches on sixteen ones after a valid word, clears on read.
// - status bits 8 to 13 show queue head; bit 14 is real-time empty.
// - overflow flag in bit 15 latches on a lost word, clears on read.
`timescale 1ns/1ns
`default_nettype none
module far_end_alarm_code_ctrl
  import alarm_code_pkg::*;
#(
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // host register port
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [15:0] rdata,
  // framer mode
  input  wire logic        e3_mode,
  input  wire logic        t3_cbit_parity,
  input  wire logic        e3_spare_source_sel0,
  input  wire logic        e3_spare_source_sel1,
  // overhead bit slots
  input  wire logic        tx_slot,
  output logic             tx_bit,
  output logic             tx_bit_valid,
  input  wire logic        rx_slot,
  input  wire logic        rx_bit,
  // interrupt request toward the master status logic
  output logic             irq
);

  // ==========================================================================
  // enable and registers
  // ==========================================================================
  logic        active;
  logic [15:0] alarm_code_control_reg;
  logic        rst_prev_reg;
  logic        rx_reset;
  logic        status_rd;
  logic [5:0]  tx_word_a_payload;
  logic [5:0]  tx_word_b_payload;
  logic [1:0]  tx_sel;
  logic        rx_idle_irq_enable;
  logic        tx_spare_enable;

  assign active = e3_mode | t3_cbit_parity;
  // e3 select code 01 routes the spare bit to this controller
  assign tx_spare_enable = e3_mode ? (~e3_spare_source_sel1 & e3_spare_source_sel0)
                                   : t3_cbit_parity;
  assign tx_word_a_payload  = alarm_code_control_reg[CTL_WORD_A_LSB +: 6];
  assign tx_word_b_payload  = alarm_code_control_reg[CTL_WORD_B_LSB +: 6];
  assign tx_sel             = alarm_code_control_reg[CTL_SEL_LSB +: 2];
  assign rx_idle_irq_enable = alarm_code_control_reg[CTL_IDLE_IE_BIT];
  assign status_rd          = clk_en & rd_stb & (addr == ALARM_CODE_STATUS_OFS);
  assign rx_reset = clk_en & alarm_code_control_reg[CTL_RX_RESET_BIT] & ~rst_prev_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_code_control_reg <= CTL_RESET_VALUE;
      rst_prev_reg           <= 1'b0;
    end else if (clk_en) begin
      rst_prev_reg <= alarm_code_control_reg[CTL_RX_RESET_BIT];
      if (wr_stb && addr == ALARM_CODE_CONTROL_OFS) begin
        alarm_code_control_reg <= wdata;
      end
    end
  end

  // ==========================================================================
  // transmit generator
  // ==========================================================================
  tx_state_t   tx_state_reg;
  logic [1:0]  sel_prev_reg;
  logic [3:0]  bit_cnt_reg;
  logic [3:0]  rep_cnt_reg;
  logic        seq_b_reg;
  logic        sel_edge;
  logic [15:0] tx_word;

  // changes from idle to a non-idle action start a sequence
  assign sel_edge = (sel_prev_reg == SEL_IDLE) && (tx_sel != SEL_IDLE);
  assign tx_word = {1'b0, (tx_state_reg == TX_SEND_B) ? tx_word_b_payload
                                                      : tx_word_a_payload,
                    1'b0, WORD_FLAG};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_reg <= TX_IDLE;
      sel_prev_reg <= SEL_IDLE;
      bit_cnt_reg  <= 4'h0;
      rep_cnt_reg  <= 4'h0;
      seq_b_reg    <= 1'b0;
      tx_bit       <= 1'b1;
      tx_bit_valid <= 1'b0;
    end else if (clk_en) begin
      sel_prev_reg <= tx_sel;
      tx_bit_valid <= tx_slot & tx_spare_enable;
      if (sel_edge && tx_state_reg != TX_SEND_A && tx_state_reg != TX_SEND_B) begin
        tx_state_reg <= TX_SEND_A;
        seq_b_reg    <= (tx_sel == SEL_A_THEN_B);
        bit_cnt_reg  <= 4'h0;
        rep_cnt_reg  <= 4'h0;
      end else if (tx_sel == SEL_IDLE && tx_state_reg == TX_DONE) begin
        tx_state_reg <= TX_IDLE;
      end
      if (tx_slot && tx_spare_enable) begin
        case (tx_state_reg)
          TX_SEND_A, TX_SEND_B: begin
            tx_bit      <= tx_word[bit_cnt_reg];
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'(WORD_BITS - 1)) begin
              if (rep_cnt_reg == 4'(TX_REPEATS - 1)) begin
                rep_cnt_reg <= 4'h0;
                if (tx_state_reg == TX_SEND_A && seq_b_reg) begin
                  tx_state_reg <= TX_SEND_B;
                end else if (tx_state_reg == TX_SEND_A && tx_sel == SEL_A_CONT) begin
                  tx_state_reg <= TX_SEND_A;
                end else begin
                  tx_state_reg <= TX_DONE;
                end
              end else begin
                rep_cnt_reg <= rep_cnt_reg + 4'h1;
              end
            end
          end
          default: begin
            tx_bit <= 1'b1;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // receive detector
  // ==========================================================================
  logic [15:0] rx_shift_reg;
  logic [3:0]  rx_phase_reg;
  logic        rx_locked_reg;
  logic        rx_valid_reg;
  logic [5:0]  rx_cand_reg;
  logic [1:0]  rx_match_cnt_reg;
  logic        rx_bad_reg;
  logic [4:0]  rx_ones_reg;
  logic        rx_idle_armed_reg;
  logic [15:0] rx_shift_next;
  logic        rx_pattern;
  logic        rx_opportunity;
  logic        rx_validate;
  logic        rx_idle_event;

  assign rx_shift_next  = {rx_bit, rx_shift_reg[15:1]};
  // newest bit sits at the top, so the flag byte lands low once a word is in
  assign rx_pattern     = (rx_shift_next[7:0] == WORD_FLAG) && !rx_shift_next[8]
                          && !rx_shift_next[15];
  assign rx_opportunity = rx_slot && active && rx_locked_reg && rx_phase_reg == 4'hf;
  assign rx_validate    = rx_opportunity && rx_pattern && !rx_valid_reg
                          && rx_shift_next[14:9] == rx_cand_reg
                          && rx_match_cnt_reg == 2'(RX_VALIDATE_CNT - 1);
  assign rx_idle_event  = clk_en && rx_slot && active && rx_idle_armed_reg && rx_bit
                          && rx_ones_reg == 5'(RX_IDLE_ONES - 1);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift_reg      <= 16'h0000;
      rx_phase_reg      <= 4'h0;
      rx_locked_reg     <= 1'b0;
      rx_valid_reg      <= 1'b0;
      rx_cand_reg       <= 6'h00;
      rx_match_cnt_reg  <= 2'h0;
      rx_bad_reg        <= 1'b0;
      rx_ones_reg       <= 5'h00;
      rx_idle_armed_reg <= 1'b0;
    end else if (rx_reset) begin
      rx_shift_reg      <= 16'h0000;
      rx_phase_reg      <= 4'h0;
      rx_locked_reg     <= 1'b0;
      rx_valid_reg      <= 1'b0;
      rx_match_cnt_reg  <= 2'h0;
      rx_bad_reg        <= 1'b0;
      rx_ones_reg       <= 5'h00;
      rx_idle_armed_reg <= 1'b0;
    end else if (clk_en && rx_slot && active) begin
      rx_shift_reg <= rx_shift_next;
      rx_phase_reg <= rx_phase_reg + 4'h1;
      rx_ones_reg  <= rx_bit ? ((rx_ones_reg == 5'(RX_IDLE_ONES - 1)) ? 5'h00
                                                                        : rx_ones_reg + 5'h01)
                             : 5'h00;
      if (rx_idle_event) begin
        rx_idle_armed_reg <= 1'b0;
      end
      if (!rx_locked_reg) begin
        if (rx_pattern) begin
          rx_locked_reg    <= 1'b1;
          rx_phase_reg     <= 4'h0;
          rx_cand_reg      <= rx_shift_next[14:9];
          rx_match_cnt_reg <= 2'h1;
        end
      end else if (rx_phase_reg == 4'hf) begin
        rx_phase_reg <= 4'h0;
        if (rx_pattern && rx_shift_next[14:9] == rx_cand_reg) begin
          rx_bad_reg <= 1'b0;
          if (!rx_valid_reg) begin
            if (rx_validate) begin
              rx_valid_reg      <= 1'b1;
              rx_idle_armed_reg <= 1'b1;
              rx_ones_reg       <= 5'h00;
            end else begin
              rx_match_cnt_reg <= rx_match_cnt_reg + 2'h1;
            end
          end
        end else if (rx_valid_reg && !rx_bad_reg) begin
          rx_bad_reg <= 1'b1;
        end else begin
          // second bad opportunity, or mismatch before validation: resume sliding search
          rx_valid_reg     <= 1'b0;
          rx_bad_reg       <= 1'b0;
          rx_locked_reg    <= 1'b0;
          rx_match_cnt_reg <= 2'h0;
        end
      end
    end
  end

  // ==========================================================================
  // receive queue and status
  // ==========================================================================
  localparam int PW = $clog2(FIFO_DEPTH);
  logic [5:0]  fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0]   count_reg;
  logic        fifo_full;
  logic        fifo_empty;
  logic        push;
  logic        pop;
  logic        detected_reg;
  logic        idle_seen_reg;
  logic        overflow_reg;

  assign fifo_full  = count_reg == (PW+1)'(FIFO_DEPTH);
  assign fifo_empty = count_reg == '0;
  assign push = clk_en && rx_validate && !rx_reset && !fifo_full;
  assign pop  = status_rd && !fifo_empty && !rx_reset;

  always_ff @(posedge mclk) begin
    if (push) begin
      fifo_mem[wr_ptr_reg] <= rx_shift_next[14:9];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (rx_reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= PW'(wr_ptr_reg + 1'b1);
      end
      if (pop) begin
        rd_ptr_reg <= PW'(rd_ptr_reg + 1'b1);
      end
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // status flags: a new event in the read cycle survives the clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      detected_reg  <= 1'b0;
      idle_seen_reg <= 1'b0;
      overflow_reg  <= 1'b0;
    end else if (clk_en) begin
      detected_reg  <= (clk_en && rx_validate && !rx_reset) | (detected_reg & ~status_rd);
      idle_seen_reg <= (rx_idle_event && !rx_reset) | (idle_seen_reg & ~status_rd);
      overflow_reg  <= (rx_validate && fifo_full && !rx_reset)
                       | (overflow_reg & ~status_rd);
    end
  end

  // ==========================================================================
  // read port and interrupt
  // ==========================================================================
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
      irq   <= 1'b0;
    end else if (clk_en) begin
      irq <= detected_reg | (idle_seen_reg & rx_idle_irq_enable);
      if (rd_stb && addr == ALARM_CODE_CONTROL_OFS) begin
        rdata <= alarm_code_control_reg;
      end else if (status_rd) begin
        rdata <= '0;
        rdata[STS_DETECTED_BIT] <= detected_reg;
        rdata[STS_IDLE_BIT]     <= idle_seen_reg;
        rdata[STS_PAYLOAD_LSB +: 6] <= fifo_empty ? 6'h00 : fifo_mem[rd_ptr_reg];
        rdata[STS_EMPTY_BIT]    <= fifo_empty;
        rdata[STS_OVERFLOW_BIT] <= overflow_reg;
      end else begin
        rdata <= 16'h0000;
      end
    end
  end

endmodule : far_end_alarm_code_ctrl
`default_nettype wire

// ### bench/alarm_code_checker.sv
// checker: port-level properties of the alarm code controller
// assumes clk_en is held high; frozen cycles are not modelled
`timescale 1ns/1ns
`default_nettype none
module alarm_code_checker
  import alarm_code_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // host port
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [15:0] rdata,
  // framer mode and slots
  input wire logic        e3_mode,
  input wire logic        t3_cbit_parity,
  input wire logic        e3_spare_source_sel0,
  input wire logic        e3_spare_source_sel1,
  input wire logic        tx_slot,
  input wire logic        tx_bit,
  input wire logic        tx_bit_valid,
  input wire logic        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // helper logic
  logic [15:0] ctl_reg;
  logic [7:0]  idle_slots_reg;
  logic        own_w;
  assign own_w = e3_mode ? (e3_spare_source_sel0 && !e3_spare_source_sel1) : t3_cbit_parity;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) ctl_reg <= CTL_RESET_VALUE;
    else if (wr_stb && addr == ALARM_CODE_CONTROL_OFS) ctl_reg <= wdata;
  end
  // a select-11 run may finish its block of ten, so idle is judged only late
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) idle_slots_reg <= 8'h00;
    else if (ctl_reg[7:6] != SEL_IDLE) idle_slots_reg <= 8'h00;
    else if (tx_bit_valid && idle_slots_reg != 8'hff) idle_slots_reg <= idle_slots_reg + 8'h01;
  end
  sequence rx_reset_rise_s;
    wr_stb && addr == ALARM_CODE_CONTROL_OFS && wdata[CTL_RX_RESET_BIT] && !ctl_reg[15];
  endsequence
  sequence status_read_s;
    rd_stb && addr == ALARM_CODE_STATUS_OFS;
  endsequence
  // ==========================================
  // properties
  rdata_idle_a: assert property (
    !(rd_stb && (addr == ALARM_CODE_CONTROL_OFS || addr == ALARM_CODE_STATUS_OFS))
    |=> rdata == 16'h0000) else $error("read data not zero");
  tx_hold_a: assert property (!tx_slot |=> $stable(tx_bit))
    else $error("tx bit moved off slot");
  tx_owner_a: assert property (1'b1 |=> tx_bit_valid == $past(tx_slot && own_w))
    else $error("tx slot ownership wrong");
  tx_mute_a: assert property (idle_slots_reg > 8'haa && tx_bit_valid |-> tx_bit)
    else $error("tx not ones in idle");
  // the flush lands one edge after the write; a read sampled at that same edge still sees the old queue
  rx_flush_a: assert property (rx_reset_rise_s ##[2:4] status_read_s |=> rdata[STS_EMPTY_BIT])
    else $error("queue not flushed");
  empty_head_a: assert property (
    status_read_s ##1 rdata[STS_EMPTY_BIT] |-> rdata[13:8] == 6'h00)
    else $error("payload shown while empty");
  detect_irq_a: assert property (
    status_read_s ##1 rdata[STS_DETECTED_BIT] |-> irq || $past(irq))
    else $error("detect without irq");
  quiet_irq_a: assert property (status_read_s ##1 rdata[1:0] == 2'b00 |-> ##1 !irq)
    else $error("irq without flag");
endmodule // alarm_code_checker
bind far_end_alarm_code_ctrl alarm_code_checker chk_u (
  .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata(rdata), .e3_mode(e3_mode), .t3_cbit_parity(t3_cbit_parity),
  .e3_spare_source_sel0(e3_spare_source_sel0), .e3_spare_source_sel1(e3_spare_source_sel1),
  .tx_slot(tx_slot), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .irq(irq));
`default_nettype wire

// ### bench/framer_slot_model.sv
// framer overhead slot model: paces both slots, feeds rx bits, gathers tx bits
// assumes the bench fills rx_q and reads tx_q through hierarchy
`timescale 1ns/1ns
`default_nettype none
module framer_slot_model #(
  parameter int SLOT_GAP = 4
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // overhead slots
  output logic      tx_slot,
  input  wire logic tx_bit,
  input  wire logic tx_bit_valid,
  output logic      rx_slot,
  output logic      rx_bit
);
  bit rx_q[$];
  bit tx_q[$];
  int gap_cnt;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt <= 0;
      tx_slot <= 1'b0;
      rx_slot <= 1'b0;
      rx_bit  <= 1'b1;
    end else begin
      gap_cnt <= (gap_cnt + 1) % SLOT_GAP;
      tx_slot <= (gap_cnt == 0);
      rx_slot <= (gap_cnt == 0);
      // outside a slot the line means nothing, so it toggles
      if (gap_cnt == 0) rx_bit <= (rx_q.size() > 0) ? rx_q.pop_front() : 1'b1;
      else rx_bit <= ~rx_bit;
      if (tx_bit_valid) tx_q.push_back(tx_bit);
    end
  end
endmodule // framer_slot_model
`default_nettype wire

// ### bench/tb_far_end_alarm_code_ctrl.sv
// self-checking bench for the far-end alarm code controller
// assumes the slot model offers both overhead slots every GAP cycles
`timescale 1ns/1ns
`default_nettype none
module tb_far_end_alarm_code_ctrl
  import alarm_code_pkg::*;
;
  localparam int GAP = 4;
  logic        mclk = 1'b0;
  logic        rst_n, wr_stb, rd_stb, e3_mode, t3_cbit_parity, sel0, sel1;
  logic        tx_slot, tx_bit, tx_bit_valid, rx_slot, rx_bit, irq;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, rd_val;
  logic [5:0]  p, q[5];
  int          seed = 90291;
  int          mismatches = 0;
  int          tests_run = 0;
  always #5 mclk = ~mclk;
  far_end_alarm_code_ctrl dut_u (.mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .e3_mode(e3_mode),
    .t3_cbit_parity(t3_cbit_parity), .e3_spare_source_sel0(sel0),
    .e3_spare_source_sel1(sel1), .tx_slot(tx_slot), .tx_bit(tx_bit),
    .tx_bit_valid(tx_bit_valid), .rx_slot(rx_slot), .rx_bit(rx_bit), .irq(irq));
  framer_slot_model #(.SLOT_GAP(GAP)) fsm (.mclk(mclk), .rst_n(rst_n), .tx_slot(tx_slot),
    .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .rx_slot(rx_slot), .rx_bit(rx_bit));
  // ==========================================
  // helpers
  function automatic logic [15:0] cw(input logic [5:0] d);
    return {1'b0, d, 1'b0, WORD_FLAG};
  endfunction
  function automatic logic [5:0] rnd6();
    return 6'($random(seed));
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 rd_val = rdata;
  endtask
  task automatic send_rx(input logic [5:0] d);
    logic [15:0] w;
    w = cw(d);
    repeat (3) for (int i = 0; i < WORD_BITS; i++) fsm.rx_q.push_back(w[i]);
    repeat (2 * WORD_BITS) fsm.rx_q.push_back(1'b1);
    while (fsm.rx_q.size() != 0) @(posedge mclk);
    repeat (4 * GAP) @(posedge mclk);
  endtask
  task automatic tx_run(input logic [1:0] sel, input logic [5:0] a, input logic [5:0] b,
                        input int na, input int nb, input int tail);
    int   s;
    logic e;
    wr(ALARM_CODE_CONTROL_OFS, {2'b00, b, 2'b00, a});
    fsm.tx_q.delete();
    wr(ALARM_CODE_CONTROL_OFS, {2'b00, b, sel, a});
    repeat (((na + nb + 2) * WORD_BITS + 8) * GAP) @(posedge mclk);
    wr(ALARM_CODE_CONTROL_OFS, {2'b00, b, 2'b00, a});
    repeat (12 * WORD_BITS * GAP) @(posedge mclk);
    s = -1;
    foreach (fsm.tx_q[i]) if (s < 0 && fsm.tx_q[i] == 1'b0) s = i - 8;
    check(16'(s >= 0), 16'(na > 0));
    if (s < 0) s = 0;
    for (int i = 0; i < (na + nb) * WORD_BITS + tail; i++) begin
      e = (i < na * 16) ? cw(a)[i % 16] : (i < (na + nb) * 16) ? cw(b)[i % 16] : 1'b1;
      check(16'(fsm.tx_q[s + i]), 16'(e));
    end
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    rst_n = 1'b0; addr = 8'h00; wdata = 16'h0000; wr_stb = 1'b0; rd_stb = 1'b0;
    e3_mode = 1'b1; t3_cbit_parity = 1'b0; sel0 = 1'b1; sel1 = 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(ALARM_CODE_CONTROL_OFS);
    check(rd_val, CTL_RESET_VALUE);
    rd(ALARM_CODE_STATUS_OFS);
    check(rd_val, 16'h4000);
    wr(8'h94, 16'hffff);
    rd(8'h94);
    check(rd_val, 16'h0000);
    rd(ALARM_CODE_CONTROL_OFS);
    check(rd_val, CTL_RESET_VALUE);
    tx_run(SEL_A_ONCE, 6'h3f, 6'h00, 10, 0, 16);
    tx_run(SEL_A_THEN_B, rnd6(), rnd6(), 10, 10, 16);
    tx_run(SEL_A_CONT, rnd6(), rnd6(), 10, 0, 0);
    tx_run(SEL_IDLE, rnd6(), rnd6(), 0, 0, 0);
    // plain T3 framing keeps the detector asleep
    e3_mode <= 1'b0;
    send_rx(rnd6());
    rd(ALARM_CODE_STATUS_OFS);
    check(rd_val, 16'h4000);
    // c-bit parity framing wakes the detector in t3 operation
    t3_cbit_parity <= 1'b1;
    p = rnd6();
    send_rx(p);
    rd(ALARM_CODE_STATUS_OFS);
    check(rd_val, {2'b00, p, 8'h03});
    t3_cbit_parity <= 1'b0;
    e3_mode <= 1'b1;
    sel0    <= 1'b0;
    p = rnd6();
    send_rx(p);
    rd(ALARM_CODE_STATUS_OFS);
    check(rd_val, {2'b00, p, 8'h03});
    wr(ALARM_CODE_CONTROL_OFS, 16'h4000);
    for (int k = 0; k < 5; k++) begin
      q[k] = rnd6();
      send_rx(q[k]);
    end
    check(16'(irq), 16'h0001);
    rd(ALARM_CODE_STATUS_OFS);
    check(rd_val, {2'b10, q[0], 8'h03});
    for (int k = 1; k < 4; k++) begin
      rd(ALARM_CODE_STATUS_OFS);
      check(rd_val, {2'b00, q[k], 8'h00});
    end
    rd(ALARM_CODE_STATUS_OFS);
    check(rd_val, 16'h4000);
    check(16'(irq), 16'h0000);
    send_rx(rnd6());
    wr(ALARM_CODE_CONTROL_OFS, 16'hc000);
    rd(ALARM_CODE_STATUS_OFS);
    check(rd_val & 16'hff00, 16'h4000);
    wr(ALARM_CODE_CONTROL_OFS, 16'h4000);
    tally_and_finish();
  end
  initial begin
    repeat (40000) @(posedge mclk);
    mismatches++;
    tally_and_finish();
  end
endmodule // tb_far_end_alarm_code_ctrl
`default_nettype wire
